// >>> pkg/slbist_pkg.sv
// Constants, types and helpers shared by the serial link self-test block
`default_nettype none
package slbist_pkg;
   // Frame and counter widths
   localparam int unsigned FRAME_W = 16;
   localparam int unsigned PRBS_W = 15;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned PEND_W = 5;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_ERR_CNT = 8'h08;
   localparam logic [7:0] ADDR_BCC_CNT = 8'h0c;

   // Field positions
   localparam int unsigned CTRL_COUNT_BITS = 0;
   localparam int unsigned STAT_PASS = 0;
   localparam int unsigned STAT_RUN = 1;
   localparam int unsigned STAT_LOCK = 2;
   localparam int unsigned STAT_DONE = 3;
   localparam int unsigned STAT_SEL_LSB = 4;

   // Reset values
   localparam logic CTRL_RST = 1'b0;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [4:0] PEND_RST = 5'h00;
   localparam logic [15:0] FRAME_RST = 16'h0000;

   // Test clock select codes
   localparam logic [1:0] SEL_EXT = 2'h0;
   localparam logic [1:0] SEL_50M = 2'h1;
   localparam logic [1:0] SEL_25M = 2'h2;
   localparam logic [1:0] SEL_12M5 = 2'h3;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_LOCK, ST_RUN, ST_DONE} slbist_state_t;

   // Pin levels that cross into the core clock together
   typedef struct packed {
      logic test_en;
      logic pwr_n;
      logic camera;
      logic lock;
      logic bcc_err;
      logic [1:0] clk_sel;
   } slbist_pins_t;

   // Next 16 bits of x^15+x^14+1, first bit in the msb
   function automatic logic [15:0] slbist_prbs_frame(input logic [14:0] seed);
      logic [14:0] s;
      logic b;
      logic [15:0] f;
      s = seed;
      f = FRAME_RST;
      for (int i = 0; i < 16; i++)
      begin
         b = s[14] ^ s[13];
         s = {s[13:0], b};
         f[15 - i] = b;
      end
      return f;
   endfunction

   // Adds and sticks at the top instead of wrapping
   function automatic logic [15:0] slbist_sat_add(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      return sum[16] ? 16'hffff : sum[15:0];
   endfunction
endpackage
`default_nettype wire

// >>> rtl/slbist_prbs_chk.sv
// Self-aligning pseudo-random frame checker with bit error count
`timescale 1ns/10ps
`default_nettype none
module slbist_prbs_chk
   import slbist_pkg::*;
#(
   parameter int unsigned FW = FRAME_W
)
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic enable_i,
   input wire logic frame_vld_i,
   input wire logic [FW-1:0] frame_i,
   output logic err_vld_o,
   output logic [PEND_W-1:0] err_bits_o
);
   logic [FW-1:0] prev_r, prev_nxt;
   logic primed_r, primed_nxt;
   logic err_vld_r, err_vld_nxt;
   logic [PEND_W-1:0] err_bits_r, err_bits_nxt;
   logic [FW-1:0] diff;

   // Local copy follows the last frame, so alignment is automatic
   always_comb
   begin
      prev_nxt = prev_r;
      primed_nxt = primed_r;
      err_vld_nxt = 1'b0;
      err_bits_nxt = err_bits_r;
      diff = frame_i ^ slbist_prbs_frame(prev_r[PRBS_W-1:0]);
      if (!enable_i)
         primed_nxt = 1'b0;
      else if (frame_vld_i)
      begin
         prev_nxt = frame_i;
         primed_nxt = 1'b1;
         err_bits_nxt = PEND_RST;
         for (int i = 0; i < FW; i++)
            err_bits_nxt = err_bits_nxt + PEND_W'(diff[i]);
         // First frame only seeds the reference
         err_vld_nxt = primed_r && (diff != FRAME_RST);
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         prev_r <= FRAME_RST;
         primed_r <= 1'b0;
         err_vld_r <= 1'b0;
         err_bits_r <= PEND_RST;
      end
      else
      begin
         prev_r <= prev_nxt;
         primed_r <= primed_nxt;
         err_vld_r <= err_vld_nxt;
         err_bits_r <= err_bits_nxt;
      end
   end

   assign err_vld_o = err_vld_r;
   assign err_bits_o = err_bits_r;
endmodule
`default_nettype wire

// >>> rtl/slbist_top.sv
// Deserializer-side at-speed link self test: session control, verdict pin, counters
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module slbist_top
   import slbist_pkg::*;
#(
   parameter int unsigned FW = FRAME_W
)
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic self_test_enable_i,
   input wire logic power_down_n_i,
   input wire logic camera_mode_i,
   input wire logic [1:0] clk_sel_i,
   input wire logic link_lock_i,
   input wire logic bcc_err_i,
   input wire logic rx_pclk_i,
   input wire logic [FW-1:0] rx_data_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   output logic pass_o,
   output logic ser_test_cmd_o,
   output logic [1:0] ser_clk_sel_o,
   output logic osc_bypass_o,
   output logic test_active_o
);
   // Pin synchronisers
   slbist_pins_t pins_raw;
   slbist_pins_t pins_meta_r;
   slbist_pins_t pins_r;
   logic pclk_meta_r;
   logic pclk_r;
   logic pclk_d_r;
   logic [FW-1:0] data_meta_r;
   logic [FW-1:0] data_r;

   // Session state
   slbist_state_t state_r, state_nxt;
   logic pass_r, pass_nxt;
   logic any_err_r, any_err_nxt;
   logic [PEND_W-1:0] pend_r, pend_nxt;
   logic cmd_r, cmd_nxt;
   logic [1:0] sel_r, sel_nxt;
   logic bcc_d_r, bcc_d_nxt;
   logic active_r, active_nxt, bypass_r, bypass_nxt;

   // Registers
   logic count_bits_r, count_bits_nxt;
   logic [CNT_W-1:0] err_cnt_r, err_cnt_nxt;
   logic [CNT_W-1:0] bcc_cnt_r, bcc_cnt_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;

   logic pclk_rise;
   logic pclk_edge;
   logic run;
   logic chk_err_vld;
   logic [PEND_W-1:0] chk_err_bits;
   logic [PEND_W:0] pend_sum;
   logic start;

   assign pins_raw = '{test_en: self_test_enable_i, pwr_n: power_down_n_i,
                       camera: camera_mode_i, lock: link_lock_i,
                       bcc_err: bcc_err_i, clk_sel: clk_sel_i};

   // Two stages on every pin; the pixel clock gets a third for edges
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pins_meta_r <= '0;
         pins_r <= '0;
         pclk_meta_r <= 1'b0;
         pclk_r <= 1'b0;
         pclk_d_r <= 1'b0;
         data_meta_r <= FRAME_RST;
         data_r <= FRAME_RST;
      end
      else
      begin
         pins_meta_r <= pins_raw;
         pins_r <= pins_meta_r;
         pclk_meta_r <= rx_pclk_i;
         pclk_r <= pclk_meta_r;
         pclk_d_r <= pclk_r;
         data_meta_r <= rx_data_i;
         data_r <= data_meta_r;
      end
   end

   // Data and clock share latency, so the rise finds a settled frame
   assign pclk_rise = pclk_r & ~pclk_d_r;
   assign pclk_edge = pclk_r ^ pclk_d_r;
   assign run = active_r;

   slbist_prbs_chk #(
      .FW(FW)
   ) u_chk (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .enable_i(run),
      .frame_vld_i(pclk_rise),
      .frame_i(data_r),
      .err_vld_o(chk_err_vld),
      .err_bits_o(chk_err_bits)
   );

   // A new session may start from idle or after a finished one
   assign start = pins_r.test_en && pins_r.camera && pins_r.pwr_n &&
                  (state_r == ST_IDLE || state_r == ST_DONE);
   assign pend_sum = {1'b0, pend_r} + {1'b0, chk_err_bits};

   // Session sequencing and the verdict pin
   always_comb
   begin
      state_nxt = state_r;
      pass_nxt = pass_r;
      any_err_nxt = any_err_r;
      pend_nxt = pend_r;
      cmd_nxt = cmd_r;
      sel_nxt = sel_r;
      bcc_d_nxt = pins_r.bcc_err;
      err_cnt_nxt = err_cnt_r;
      bcc_cnt_nxt = bcc_cnt_r;
      if (!pins_r.pwr_n)
      begin
         // Power-down ends the session, keeps the counters and leaves a passing verdict
         state_nxt = ST_IDLE;
         pass_nxt = 1'b1;
         cmd_nxt = 1'b0;
         pend_nxt = PEND_RST;
         any_err_nxt = 1'b0;
      end
      else if (start)
      begin
         state_nxt = ST_WAIT_LOCK;
         cmd_nxt = 1'b1;
         sel_nxt = pins_r.clk_sel;
         pass_nxt = 1'b1;
         any_err_nxt = 1'b0;
         pend_nxt = PEND_RST;
         err_cnt_nxt = CNT_RST;
         bcc_cnt_nxt = CNT_RST;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               cmd_nxt = 1'b0;
            end
            ST_WAIT_LOCK:
            begin
               if (!pins_r.test_en || !pins_r.camera)
               begin
                  state_nxt = ST_DONE;
                  cmd_nxt = 1'b0;
                  pass_nxt = ~any_err_r;
               end
               else if (pins_r.lock)
                  state_nxt = ST_RUN;
            end
            ST_RUN:
            begin
               if (!pins_r.test_en || !pins_r.camera)
               begin
                  // Anything arriving now is outside the window
                  state_nxt = ST_DONE;
                  cmd_nxt = 1'b0;
                  pass_nxt = ~any_err_r;
                  pend_nxt = PEND_RST;
               end
               else if (!pins_r.lock)
               begin
                  // Lock loss pauses the window; unlocked data is not judged
                  state_nxt = ST_WAIT_LOCK;
                  pass_nxt = 1'b1;
                  pend_nxt = PEND_RST;
               end
               else
               begin
                  if (chk_err_vld)
                  begin
                     any_err_nxt = 1'b1;
                     err_cnt_nxt = slbist_sat_add(err_cnt_r, count_bits_r ?
                        CNT_W'(chk_err_bits) : CNT_W'(1));
                  end
                  // One low half-cycle queued per bad bit, saturating
                  if (pclk_edge)
                  begin
                     if (pass_r && pend_r != PEND_RST)
                     begin
                        pass_nxt = 1'b0;
                        pend_nxt = pend_r - PEND_W'(1);
                     end
                     else
                        pass_nxt = 1'b1;
                  end
                  if (chk_err_vld)
                     pend_nxt = pend_sum[PEND_W] ? {PEND_W{1'b1}} :
                        (pend_sum[PEND_W-1:0] - PEND_W'(pclk_edge && pass_r && pend_r != PEND_RST));
                  // Serializer error flag rises count as control-channel errors
                  if (pins_r.bcc_err && !bcc_d_r)
                     bcc_cnt_nxt = slbist_sat_add(bcc_cnt_r, CNT_W'(1));
               end
            end
            ST_DONE:
            begin
               cmd_nxt = 1'b0;
            end
            default:
            begin
               state_nxt = ST_IDLE;
            end
         endcase
      end
      active_nxt = (state_nxt == ST_RUN);
      bypass_nxt = cmd_nxt && (sel_nxt == SEL_EXT);
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_r <= ST_IDLE;
         pass_r <= 1'b1;
         any_err_r <= 1'b0;
         pend_r <= PEND_RST;
         cmd_r <= 1'b0;
         sel_r <= SEL_EXT;
         bcc_d_r <= 1'b0;
         err_cnt_r <= CNT_RST;
         bcc_cnt_r <= CNT_RST;
         active_r <= 1'b0;
         bypass_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         pass_r <= pass_nxt;
         any_err_r <= any_err_nxt;
         pend_r <= pend_nxt;
         cmd_r <= cmd_nxt;
         sel_r <= sel_nxt;
         bcc_d_r <= bcc_d_nxt;
         err_cnt_r <= err_cnt_nxt;
         bcc_cnt_r <= bcc_cnt_nxt;
         active_r <= active_nxt;
         bypass_r <= bypass_nxt;
      end
   end

   // Register write and read decode; unmapped reads return zero
   always_comb
   begin
      count_bits_nxt = count_bits_r;
      rdata_nxt = '0;
      if (reg_wr_i && reg_addr_i == ADDR_CTRL)
         count_bits_nxt = reg_wdata_i[CTRL_COUNT_BITS];
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            ADDR_CTRL:
            begin
               rdata_nxt[CTRL_COUNT_BITS] = count_bits_r;
            end
            ADDR_STATUS:
            begin
               rdata_nxt[STAT_PASS] = pass_r;
               rdata_nxt[STAT_RUN] = run;
               rdata_nxt[STAT_LOCK] = pins_r.lock;
               rdata_nxt[STAT_DONE] = (state_r == ST_DONE);
               rdata_nxt[STAT_SEL_LSB +: 2] = sel_r;
            end
            ADDR_ERR_CNT:
            begin
               rdata_nxt[CNT_W-1:0] = err_cnt_r;
            end
            ADDR_BCC_CNT:
            begin
               rdata_nxt[CNT_W-1:0] = bcc_cnt_r;
            end
            default:
            begin
               rdata_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         count_bits_r <= CTRL_RST;
         rdata_r <= '0;
      end
      else
      begin
         count_bits_r <= count_bits_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Outputs come straight from flops
   assign reg_rdata_o = rdata_r;
   assign pass_o = pass_r;
   assign ser_test_cmd_o = cmd_r;
   assign ser_clk_sel_o = sel_r;
   assign osc_bypass_o = bypass_r;
   assign test_active_o = active_r;
endmodule
`default_nettype wire

// >>> tb/slbist_top_sva.sv
// Assertion checker for the serial link self-test top
`timescale 1ns/10ps
`default_nettype none
module slbist_top_sva
   import slbist_pkg::*;
#(
   parameter int unsigned FW = FRAME_W
)
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic self_test_enable_i,
   input wire logic power_down_n_i,
   input wire logic camera_mode_i,
   input wire logic [1:0] clk_sel_i,
   input wire logic link_lock_i,
   input wire logic bcc_err_i,
   input wire logic rx_pclk_i,
   input wire logic [FW-1:0] rx_data_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [DATA_W-1:0] reg_rdata_o,
   input wire logic pass_o,
   input wire logic ser_test_cmd_o,
   input wire logic [1:0] ser_clk_sel_o,
   input wire logic osc_bypass_o,
   input wire logic test_active_o
);
   // Pins pass two sync flops and a state flop, hence the three-edge figures
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);
   a_cmd_start: assert property (
      $rose(ser_test_cmd_o) |-> pass_o && $past(self_test_enable_i, 3) && $past(camera_mode_i, 3))
      else $error("command rose without enable");
   a_display_idle: assert property (
      !camera_mode_i [*4] |-> !ser_test_cmd_o)
      else $error("command up in display mode");
   a_enable_off: assert property (
      !self_test_enable_i [*4] |-> !ser_test_cmd_o)
      else $error("command up after enable fell");
   a_run_lock: assert property (
      $rose(test_active_o) |-> ser_test_cmd_o && $past(link_lock_i, 3))
      else $error("window opened without lock");
   a_active_cmd: assert property (
      test_active_o |-> ser_test_cmd_o)
      else $error("window open without command");
   a_sel_hold: assert property (
      ser_test_cmd_o && $past(ser_test_cmd_o) |-> $stable(ser_clk_sel_o))
      else $error("clock select moved in session");
   a_bypass_ext: assert property (
      osc_bypass_o == (ser_test_cmd_o && ser_clk_sel_o == SEL_EXT))
      else $error("bypass disagrees with select");
   a_pd_pass: assert property (
      !power_down_n_i [*4] |-> pass_o && !ser_test_cmd_o)
      else $error("power down did not idle");
   a_verdict_hold: assert property (
      (power_down_n_i && !ser_test_cmd_o) [*4] |-> $stable(pass_o))
      else $error("verdict moved outside session");
   a_fall_in_test: assert property (
      $fell(pass_o) |-> $past(ser_test_cmd_o))
      else $error("verdict fell outside session");
   a_rdata_zero: assert property (
      !reg_rd_i |=> reg_rdata_o == '0)
      else $error("read data without read");
endmodule
bind slbist_top slbist_top_sva #(.FW(FW)) u_sva (
   .core_clk_i(core_clk_i), .resetn_i(resetn_i), .self_test_enable_i(self_test_enable_i),
   .power_down_n_i(power_down_n_i), .camera_mode_i(camera_mode_i), .clk_sel_i(clk_sel_i),
   .link_lock_i(link_lock_i), .bcc_err_i(bcc_err_i), .rx_pclk_i(rx_pclk_i), .rx_data_i(rx_data_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .pass_o(pass_o), .ser_test_cmd_o(ser_test_cmd_o),
   .ser_clk_sel_o(ser_clk_sel_o), .osc_bypass_o(osc_bypass_o), .test_active_o(test_active_o)
);
`default_nettype wire

// >>> tb/slbist_ser_model.sv
// Far-side serializer model sending pseudo-random frames on its pixel clock
`timescale 1ns/10ps
`default_nettype none
module slbist_ser_model
(
   input wire logic run_i,
   input wire logic err_req_i,
   input wire logic [15:0] err_mask_i,
   output logic pclk_o,
   output logic [15:0] data_o
);
   logic [14:0] lfsr = 15'h0001;
   logic req_seen = 1'b0;
   logic [15:0] f;
   initial pclk_o = 1'b0;
   initial data_o = 16'h0000;
   // Clock runs in any select mode while commanded, stands low otherwise
   always
   begin
      if (run_i === 1'b1)
         #160 pclk_o = ~pclk_o;
      else
      begin
         pclk_o = 1'b0;
         @(posedge run_i);
         #7;
      end
   end
   // New frame on the falling edge, steady at the rising one
   always @(negedge pclk_o)
   begin
      if (run_i === 1'b1)
      begin
         for (int i = 15; i >= 0; i--)
         begin
            f[i] = lfsr[14] ^ lfsr[13];
            lfsr = {lfsr[13:0], f[i]};
         end
         if (err_req_i != req_seen)
            f = f ^ err_mask_i;
         req_seen = err_req_i;
         data_o <= f;
      end
   end
   // Released line no longer shows the last frame
   always @(negedge run_i)
      data_o <= ~data_o;
endmodule
`default_nettype wire

// >>> tb/slbist_top_bench.sv
// Self-checking bench for the serial link self-test top
`timescale 1ns/10ps
`default_nettype none
module slbist_top_bench;
   import slbist_pkg::*;
   logic core_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic en = 1'b0, pd_n = 1'b1, cam = 1'b1, lock = 1'b0, bcc = 1'b0;
   logic wr = 1'b0, rd = 1'b0, err_req = 1'b0;
   logic [1:0] sel = 2'h0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [15:0] err_mask = 16'h0000;
   logic pclk, pass, cmd, bypass, active;
   logic [1:0] ssel;
   logic [15:0] rxd;
   logic [31:0] rdata, got;
   int n_mismatch = 0, num_checks = 0, n_fall = 0;
   always #20 core_clk_i = ~core_clk_i;
   // Low pulses on the verdict pin
   always @(negedge pass)
      n_fall++;
   slbist_top u_dut (
      .core_clk_i(core_clk_i), .resetn_i(resetn_i), .self_test_enable_i(en), .power_down_n_i(pd_n),
      .camera_mode_i(cam), .clk_sel_i(sel), .link_lock_i(lock), .bcc_err_i(bcc), .rx_pclk_i(pclk),
      .rx_data_i(rxd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .pass_o(pass), .ser_test_cmd_o(cmd), .ser_clk_sel_o(ssel),
      .osc_bypass_o(bypass), .test_active_o(active)
   );
   slbist_ser_model u_ser (
      .run_i(cmd), .err_req_i(err_req), .err_mask_i(err_mask), .pclk_o(pclk), .data_o(rxd)
   );
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Bounded wait on the window pin or the command pin; a hang counts as a mismatch
   task automatic wait_on(input logic on_active, input logic v);
      for (int i = 0; i < 3000 && (on_active ? active : cmd) !== v; i++)
      begin
         @(posedge core_clk_i);
         #1;
      end
      if ((on_active ? active : cmd) !== v)
      begin
         n_mismatch++;
         stop_test();
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1 got = rdata;
      chk(got, e);
   endtask
   task automatic start(input logic [1:0] s);
      @(posedge core_clk_i);
      cam <= 1'b1;
      sel <= s;
      en <= 1'b1;
      wait_on(1'b0, 1'b1);
      repeat (24) @(posedge core_clk_i);
      #1 chk(active, 1'b0);
      @(posedge core_clk_i);
      lock <= 1'b1;
      wait_on(1'b1, 1'b1);
   endtask
   task automatic stop();
      @(posedge core_clk_i);
      en <= 1'b0;
      wait_on(1'b0, 1'b0);
      @(posedge core_clk_i);
      lock <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      #1;
   endtask
   task automatic inject(input logic [15:0] m);
      repeat (40) @(posedge core_clk_i);
      err_mask <= m;
      err_req <= ~err_req;
      // Long enough for every queued low half-period to drain
      repeat (100) @(posedge core_clk_i);
   endtask
   initial
   begin
      int k;
      repeat (8) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      @(posedge core_clk_i);
      #1 chk(pass, 1'b1);
      chk(cmd, 1'b0);
      rchk(ADDR_CTRL, 32'h0);
      rchk(ADDR_ERR_CNT, 32'h0);
      rchk(8'h10, 32'h0);
      wr_reg(ADDR_CTRL, 32'h1);
      rchk(ADDR_CTRL, 32'h1);
      wr_reg(ADDR_CTRL, 32'h0);
      // Display operation with enable up
      @(posedge core_clk_i);
      cam <= 1'b0;
      en <= 1'b1;
      repeat (12) @(posedge core_clk_i);
      #1 chk(cmd, 1'b0);
      @(posedge core_clk_i);
      en <= 1'b0;
      // One bad bit, frames counted
      start(SEL_25M);
      n_fall = 0;
      inject(16'h0100);
      chk(n_fall, 32'h3);
      stop();
      chk(pass, 1'b0);
      rchk(ADDR_ERR_CNT, 32'h2);
      chk(got >= 1 && got <= 2, 1'b1);
      // Four bad bits in one frame, bits counted, control-channel errors
      wr_reg(ADDR_CTRL, 32'h1);
      start(SEL_50M);
      n_fall = 0;
      inject(16'h8421);
      chk(n_fall, 32'ha);
      for (k = 0; k < 2; k++)
      begin
         @(posedge core_clk_i);
         bcc <= 1'b1;
         repeat (4) @(posedge core_clk_i);
         bcc <= 1'b0;
         repeat (4) @(posedge core_clk_i);
      end
      rchk(ADDR_BCC_CNT, 32'h2);
      rchk(ADDR_ERR_CNT, 32'ha);
      chk(got >= 4 && got < 32'hffff, 1'b1);
      stop();
      chk(pass, 1'b0);
      // Power-down pulse restores the verdict
      @(posedge core_clk_i);
      pd_n <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      #1 chk(pass, 1'b1);
      @(posedge core_clk_i);
      pd_n <= 1'b1;
      // Lock loss pauses the window; a camera drop ends the session
      start(SEL_12M5);
      @(posedge core_clk_i);
      lock <= 1'b0;
      wait_on(1'b1, 1'b0);
      chk(cmd, 1'b1);
      rchk(ADDR_STATUS, 32'h0000_0031);
      @(posedge core_clk_i);
      lock <= 1'b1;
      wait_on(1'b1, 1'b1);
      @(posedge core_clk_i);
      cam <= 1'b0;
      wait_on(1'b0, 1'b0);
      chk(pass, 1'b1);
      rchk(ADDR_STATUS, 32'h0000_003d);
      @(posedge core_clk_i);
      en <= 1'b0;
      cam <= 1'b1;
      lock <= 1'b0;
      // Clean sessions for every clock select code
      for (k = 0; k < 4; k++)
      begin
         start(k[1:0]);
         rchk(ADDR_ERR_CNT, 32'h0);
         rchk(ADDR_BCC_CNT, 32'h0);
         chk(ssel, k);
         chk(bypass, k == 0);
         rchk(ADDR_STATUS, {26'h0, k[1:0], 4'h7});
         repeat (160) @(posedge core_clk_i);
         stop();
         chk(pass, 1'b1);
         rchk(ADDR_STATUS, {26'h0, k[1:0], 4'h9});
      end
      stop_test();
   end
endmodule
`default_nettype wire
